// File: hdl/ecp_pkg.sv
// ecp_pkg: shared constants and types of the parallel host port
// assumes: one 125 MHz clock, 8-bit host register port
`default_nettype none

package ecp_pkg;

  // ------------------------------------------------------------------
  // register offsets (host address, 11 bits)
  // ------------------------------------------------------------------
  localparam logic [10:0] OFF_DATA = 11'h000;
  localparam logic [10:0] OFF_DSR  = 11'h001;
  localparam logic [10:0] OFF_DCR  = 11'h002;
  localparam logic [10:0] OFF_FIFO = 11'h400;
  localparam logic [10:0] OFF_CFGB = 11'h401;
  localparam logic [10:0] OFF_ECR  = 11'h402;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int DCR_STROBE = 0;
  localparam int DCR_AUTOFD = 1;
  localparam int DCR_INIT   = 2;
  localparam int DCR_SELIN  = 3;
  localparam int DCR_ACKIEN = 4;
  localparam int DCR_DIR    = 5;
  localparam int ECR_NERR   = 4;
  localparam int ECR_DMA    = 3;
  localparam int ECR_SVC    = 2;
  localparam int RLE_FLAG   = 7;

  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [5:0] DCR_RST   = 6'h00;
  localparam logic [7:0] ECR_RST   = 8'h14;
  localparam logic [7:0] CONFIG_A_VAL = 8'h10;

  // ------------------------------------------------------------------
  // port modes
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_STD  = 3'h0;
  localparam logic [2:0] MODE_BIDI = 3'h1;
  localparam logic [2:0] MODE_COMPAT_DATA_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_EPP  = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG  = 3'h7;

  // ------------------------------------------------------------------
  // fifo shape and timing
  // ------------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int CLK_NS     = 8;
  localparam int STB_NS     = 500;
  localparam logic [6:0] STB_CYC = 7'((STB_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_FSET  = 3'b001,
    HS_FSTB  = 3'b010,
    HS_FREL  = 3'b011,
    HS_RREQ  = 3'b100,
    HS_RPUSH = 3'b101,
    HS_RACKW = 3'b110
  } ecp_hs_t;

  typedef struct packed {
    logic [7:0] data;
    logic [5:0] dcr;
    logic [2:0] mode;
    logic       nerr;
    logic       dma_en;
    logic       svc;
    ecp_hs_t    hs;
    logic [6:0] cnt;
    logic [7:0] run;
    logic [7:0] rbyte;
    logic       rtag;
    logic       rle_pend;
    logic       ftag;
    logic [7:0] last_rd;
    logic [7:0] rdata;
    logic [7:0] pd_out;
    logic       pd_oe_n;
    logic       strobe_n;
    logic       autofd_n;
    logic       init_n;
    logic       selectin_n;
    logic       irq;
    logic       ack_d;
    logic       dma_req;
  } ecp_state_t;

endpackage

`default_nettype wire

// File: hdl/ecp_parallel_port.sv
// ecp_parallel_port: host register port, shared fifo and peripheral handshakes
// assumes: host strobes and all pin inputs are synchronous to clk
`default_nettype none

// ------------------------------------------------------------------
// fifo
// ------------------------------------------------------------------
module ecp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ecp_fifo_st_t;

  ecp_fifo_st_t st_reg;
  ecp_fifo_st_t st_next;
  logic         push;
  logic         pop;

  assign full      = st_reg.cnt == (AW+1)'(DEPTH);
  assign empty     = st_reg.cnt == '0;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_reg.mem[st_reg.rp];

  always_comb
  begin
    st_next = st_reg;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    if (flush)
    begin
      st_next.wp  = '0;
      st_next.rp  = '0;
      st_next.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        st_next.mem[st_reg.wp] = in_data;
        st_next.wp = st_reg.wp + AW'(1);
      end
      if (pop)
        st_next.rp = st_reg.rp + AW'(1);
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  a_fifo_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (full && !out_ready && !flush) |=> (full && st_reg.cnt == $past(st_reg.cnt)))
    else $error("full fifo changed without a pop");
  a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule // ecp_fifo

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
module ecp_parallel_port (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [10:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  input  wire logic        dma_ack,
  output logic             dma_req,
  output logic             irq,
  input  wire logic [7:0]  pd_in,
  output logic [7:0]       pd_out,
  output logic             pd_oe_n,
  output logic             strobe_n,
  output logic             autofd_n,
  output logic             init_n,
  output logic             selectin_n,
  input  wire logic        ack_n,
  input  wire logic        busy,
  input  wire logic        perror,
  input  wire logic        select,
  input  wire logic        fault_n,
  input  wire logic        unused_tie_low
);
  logic [1:0]          rst_sync;
  logic                rst_n;
  ecp_pkg::ecp_state_t st_reg;
  ecp_pkg::ecp_state_t st_next;
  logic                f_in_valid;
  logic                f_in_ready;
  logic [8:0]          f_in_data;
  logic                f_out_valid;
  logic                f_out_ready;
  logic [8:0]          f_out_data;
  logic                f_full;
  logic                f_empty;
  logic                f_flush;

  function automatic logic hit(input logic [10:0] a, input logic [10:0] off);
    hit = (a == off);
  endfunction

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ecp_fifo #(
    .WIDTH (ecp_pkg::FIFO_WIDTH),
    .DEPTH (ecp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .full      (f_full),
    .empty     (f_empty)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic m_ecp;
    logic m_cf;
    logic m_test;
    logic fwd;
    logic rev;
    logic wr_fifo;
    logic wr_afifo;
    logic rd_fifo;
    logic [7:0] pop_byte;
    m_ecp    = st_reg.mode == ecp_pkg::MODE_ECP;
    m_cf     = st_reg.mode == ecp_pkg::MODE_COMPAT_DATA_FIFO;
    m_test   = st_reg.mode == ecp_pkg::MODE_TEST;
    fwd      = m_cf || (m_ecp && !st_reg.dcr[ecp_pkg::DCR_DIR]);
    rev      = m_ecp && st_reg.dcr[ecp_pkg::DCR_DIR];
    wr_fifo  = io_wr && (dma_ack || (hit(io_addr, ecp_pkg::OFF_FIFO) && (m_cf || m_ecp || m_test)));
    wr_afifo = io_wr && !dma_ack && hit(io_addr, ecp_pkg::OFF_DATA) && m_ecp;
    rd_fifo  = io_rd && (dma_ack || (hit(io_addr, ecp_pkg::OFF_FIFO) && (m_ecp || m_test)));
    pop_byte = f_out_valid ? f_out_data[7:0] : st_reg.last_rd;
    st_next  = st_reg;
    f_flush  = 1'b0;
    f_in_valid  = 1'b0;
    f_in_data   = {1'b0, io_wdata};
    f_out_ready = 1'b0;

    // host side fifo traffic; a full fifo silently drops the write
    if (wr_fifo || wr_afifo)
    begin
      f_in_valid = 1'b1;
      f_in_data  = {wr_afifo, io_wdata};
    end
    if (rd_fifo)
    begin
      f_out_ready    = 1'b1;
      st_next.last_rd = pop_byte;
    end

    // register reads
    if (io_rd)
    begin
      st_next.rdata = 8'h00;
      if (rd_fifo)
        st_next.rdata = pop_byte;
      else if (hit(io_addr, ecp_pkg::OFF_DATA))
        st_next.rdata = pd_in;
      else if (hit(io_addr, ecp_pkg::OFF_DSR))
        st_next.rdata = {!busy, ack_n, perror, select, fault_n, 3'h0};
      else if (hit(io_addr, ecp_pkg::OFF_DCR))
        st_next.rdata = {2'h0, st_reg.dcr};
      else if (hit(io_addr, ecp_pkg::OFF_ECR))
        st_next.rdata = {st_reg.mode, st_reg.nerr, st_reg.dma_en, st_reg.svc, f_full, f_empty};
      else if (st_reg.mode == ecp_pkg::MODE_CFG && hit(io_addr, ecp_pkg::OFF_FIFO))
        st_next.rdata = ecp_pkg::CONFIG_A_VAL;
      else if (st_reg.mode == ecp_pkg::MODE_CFG && hit(io_addr, ecp_pkg::OFF_CFGB))
        st_next.rdata = {1'b0, st_reg.irq, 6'h00};
    end

    // register writes
    if (io_wr && !dma_ack)
    begin
      if (hit(io_addr, ecp_pkg::OFF_DATA) && !m_ecp)
        st_next.data = io_wdata;
      if (hit(io_addr, ecp_pkg::OFF_DCR))
        st_next.dcr = io_wdata[5:0];
      if (hit(io_addr, ecp_pkg::OFF_ECR))
      begin
        st_next.mode   = io_wdata[7:5];
        st_next.nerr   = io_wdata[ecp_pkg::ECR_NERR];
        st_next.dma_en = io_wdata[ecp_pkg::ECR_DMA];
        st_next.svc    = io_wdata[ecp_pkg::ECR_SVC];
        f_flush = (io_wdata[7:5] == ecp_pkg::MODE_STD) || (io_wdata[7:5] == ecp_pkg::MODE_BIDI);
      end
    end

    // link handshake
    case (st_reg.hs)
      ecp_pkg::HS_IDLE:
      begin
        if (fwd && f_out_valid && !busy && !rd_fifo)
        begin
          f_out_ready    = 1'b1;
          st_next.pd_out = f_out_data[7:0];
          st_next.ftag   = f_out_data[8];
          st_next.autofd_n = !f_out_data[8];
          st_next.hs     = ecp_pkg::HS_FSET;
        end
        else if (rev && !perror && f_in_ready && !f_in_valid)
        begin
          st_next.autofd_n = 1'b0;
          st_next.hs       = ecp_pkg::HS_RREQ;
        end
      end
      ecp_pkg::HS_FSET:
      begin
        st_next.strobe_n = 1'b0;
        st_next.cnt      = ecp_pkg::STB_CYC;
        st_next.hs       = ecp_pkg::HS_FSTB;
      end
      ecp_pkg::HS_FSTB:
      begin
        if (st_reg.cnt != 7'h00)
          st_next.cnt = st_reg.cnt - 7'h01;
        if ((m_ecp && busy) || (!m_ecp && st_reg.cnt == 7'h00))
        begin
          st_next.strobe_n = 1'b1;
          st_next.hs       = ecp_pkg::HS_FREL;
        end
      end
      ecp_pkg::HS_FREL:
      begin
        if (!busy)
          st_next.hs = ecp_pkg::HS_IDLE;
      end
      ecp_pkg::HS_RREQ:
      begin
        if (!ack_n)
        begin
          st_next.autofd_n = 1'b1;
          st_next.rbyte    = pd_in;
          st_next.rtag     = !busy;
          if (!busy && !pd_in[ecp_pkg::RLE_FLAG])
          begin
            st_next.run      = {1'b0, pd_in[6:0]} + 8'h01;
            st_next.rle_pend = 1'b1;
            st_next.hs       = ecp_pkg::HS_RACKW;
          end
          else
          begin
            st_next.run      = st_reg.rle_pend ? st_reg.run : 8'h01;
            st_next.rle_pend = 1'b0;
            st_next.hs       = ecp_pkg::HS_RPUSH;
          end
        end
      end
      ecp_pkg::HS_RPUSH:
      begin
        f_in_valid = 1'b1;
        f_in_data  = {st_reg.rtag, st_reg.rbyte};
        if (f_in_ready)
        begin
          st_next.run = st_reg.run - 8'h01;
          if (st_reg.run == 8'h01)
            st_next.hs = ecp_pkg::HS_RACKW;
        end
      end
      ecp_pkg::HS_RACKW:
      begin
        if (ack_n)
          st_next.hs = ecp_pkg::HS_IDLE;
      end
      default:
        st_next.hs = ecp_pkg::HS_IDLE;
    endcase

    // pin drive per mode
    st_next.selectin_n = !st_reg.dcr[ecp_pkg::DCR_SELIN];
    st_next.init_n     = st_reg.dcr[ecp_pkg::DCR_INIT];
    if (!m_ecp && !m_cf)
    begin
      st_next.strobe_n = !st_reg.dcr[ecp_pkg::DCR_STROBE];
      st_next.autofd_n = !st_reg.dcr[ecp_pkg::DCR_AUTOFD];
      st_next.pd_out   = st_reg.data;
      st_next.hs       = ecp_pkg::HS_IDLE;
      st_next.pd_oe_n  = (st_reg.mode == ecp_pkg::MODE_STD) ? 1'b0
                         : st_reg.dcr[ecp_pkg::DCR_DIR];
    end
    else if (m_cf)
    begin
      st_next.autofd_n = !st_reg.dcr[ecp_pkg::DCR_AUTOFD];
      st_next.pd_oe_n  = 1'b0;
    end
    else
    begin
      st_next.selectin_n = 1'b1;
      st_next.init_n     = !st_reg.dcr[ecp_pkg::DCR_DIR];
      st_next.pd_oe_n    = !(!st_reg.dcr[ecp_pkg::DCR_DIR] && perror);
      if (st_reg.hs == ecp_pkg::HS_FSET || st_reg.hs == ecp_pkg::HS_FSTB)
        st_next.autofd_n = !st_reg.ftag;
    end

    // fault is only a hint; direction stays under host control
    st_next.ack_d   = ack_n;
    st_next.irq     = (!st_reg.nerr && !fault_n && !st_reg.dcr[ecp_pkg::DCR_DIR])
                      || (st_reg.dcr[ecp_pkg::DCR_ACKIEN] && ack_n && !st_reg.ack_d);
    st_next.dma_req = st_reg.dma_en && ((fwd && !f_full) || (rev && !f_empty));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg            <= '0;
      st_reg.data       <= ecp_pkg::DATA_RST;
      st_reg.dcr        <= ecp_pkg::DCR_RST;
      st_reg.mode       <= ecp_pkg::ECR_RST[7:5];
      st_reg.nerr       <= ecp_pkg::ECR_RST[ecp_pkg::ECR_NERR];
      st_reg.dma_en     <= ecp_pkg::ECR_RST[ecp_pkg::ECR_DMA];
      st_reg.svc        <= ecp_pkg::ECR_RST[ecp_pkg::ECR_SVC];
      st_reg.hs         <= ecp_pkg::HS_IDLE;
      st_reg.strobe_n   <= 1'b1;
      st_reg.autofd_n   <= 1'b1;
      st_reg.selectin_n <= 1'b1;
      st_reg.ack_d      <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign io_rdata   = st_reg.rdata;
  assign dma_req    = st_reg.dma_req;
  assign irq        = st_reg.irq;
  assign pd_out     = st_reg.pd_out;
  assign pd_oe_n    = st_reg.pd_oe_n;
  assign strobe_n   = st_reg.strobe_n;
  assign autofd_n   = st_reg.autofd_n;
  assign init_n     = st_reg.init_n;
  assign selectin_n = st_reg.selectin_n;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_selin_ecp: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.mode == ecp_pkg::MODE_ECP) |=> selectin_n)
    else $error("nselectin low in ecp mode");
  a_pd_forward: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st_reg.mode) == ecp_pkg::MODE_ECP && !pd_oe_n) |-> ($past(perror) && init_n))
    else $error("data driven outside forward state");
  a_init_dir: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(st_reg.mode) == ecp_pkg::MODE_ECP) |-> (init_n == !$past(st_reg.dcr[5])))
    else $error("ninit does not follow direction");
  a_strobe_src: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(strobe_n) && ($past(st_reg.mode) == ecp_pkg::MODE_COMPAT_DATA_FIFO
     || $past(st_reg.mode) == ecp_pkg::MODE_ECP)) |-> $past(st_reg.hs == ecp_pkg::HS_FSET))
    else $error("strobe without a fifo byte");
  a_strobe_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.hs == ecp_pkg::HS_FSTB && st_reg.mode == ecp_pkg::MODE_ECP && busy)
    |=> (strobe_n && st_reg.hs == ecp_pkg::HS_FREL))
    else $error("strobe not released on busy");
  a_rle_count: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.hs == ecp_pkg::HS_RPUSH && f_in_ready) |=> (st_reg.run == $past(st_reg.run) - 8'h01))
    else $error("run-length repeat miscounted");
  a_rev_req: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.hs == ecp_pkg::HS_RREQ && !ack_n) |=> (autofd_n && st_reg.hs != ecp_pkg::HS_RREQ))
    else $error("reverse request not closed on nack");
  a_fwd_tag: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.hs == ecp_pkg::HS_FSTB && st_reg.mode == ecp_pkg::MODE_ECP
     && $past(st_reg.mode) == ecp_pkg::MODE_ECP) |-> (autofd_n == !st_reg.ftag))
    else $error("nautofd does not mark byte type");
  a_err_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (!st_reg.nerr && !fault_n && !st_reg.dcr[5]) |=> irq)
    else $error("fault did not raise interrupt");
  a_fault_hint: assert property (@(posedge clk) disable iff (!rst_n)
    (!fault_n && !io_wr) |=> $stable(st_reg.dcr))
    else $error("fault changed direction");
  a_dsr_read: assert property (@(posedge clk) disable iff (!rst_n)
    (io_rd && !dma_ack && io_addr == ecp_pkg::OFF_DSR)
    |=> (io_rdata == {!$past(busy), $past(ack_n), $past(perror), $past(select),
                      $past(fault_n), 3'h0}))
    else $error("status read wrong");
endmodule // ecp_parallel_port

`default_nettype wire

// File: verification/ecp_periph.sv
// ecp_periph: behavioural parallel peripheral for the port bench
// assumes: shares clk with the port; bench loads rq and drains fq
`default_nettype none

module ecp_periph (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic       autofd_n,
  input  wire logic       init_n,
  input  wire logic       selectin_n,
  input  wire logic [7:0] pd_out,
  output var  logic       busy,
  output var  logic       ack_n,
  output var  logic       perror,
  output var  logic [7:0] pp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] fq[$];
  logic [8:0] rq[$];

  // direction acknowledge follows the request one cycle late
  always @(posedge clk) perror <= init_n;
  initial
  begin
    busy = 1'b0;
    ack_n = 1'b1;
    pp = 8'h00;
    forever
    begin
      @(posedge clk);
      #1;
      if (!strobe_n)
      begin
        fq.push_back({~autofd_n, pd_out});
        busy = 1'b1;
        while (!strobe_n)
        begin
          @(posedge clk);
          #1;
        end
        busy = 1'b0;
      end
      else if (!autofd_n && selectin_n && rq.size() > 0)
      begin
        {busy, pp} = rq.pop_front();
        ack_n = 1'b0;
        while (!autofd_n)
        begin
          @(posedge clk);
          #1;
        end
        ack_n = 1'b1;
        pp = ~pp;
      end
    end
  end
endmodule // ecp_periph

`default_nettype wire

// File: verification/ecp_parallel_port_tb.sv
// ecp_parallel_port_tb: self-checking bench for the parallel host port
// assumes: design under hdl/, peripheral model ecp_periph beside it
`default_nettype none

module ecp_parallel_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, io_rd, io_wr, dma_ack, dma_req, irq, pd_oe_n;
  logic        strobe_n, autofd_n, init_n, selectin_n, ack_n, busy, perror;
  logic        select, fault_n;
  logic [10:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, pd_in, pd_out, pp, d;
  logic [1:0]  sf;
  logic [8:0]  eq[$];
  logic [7:0]  tq[$];
  int          bad_count, n_compared;

  assign pd_in = pd_oe_n ? pp : pd_out;
  ecp_parallel_port DUT (.clk, .reset_n, .io_addr, .io_rd, .io_wr, .io_wdata,
    .io_rdata, .dma_ack, .dma_req, .irq, .pd_in, .pd_out, .pd_oe_n, .strobe_n,
    .autofd_n, .init_n, .selectin_n, .ack_n, .busy, .perror, .select, .fault_n,
    .unused_tie_low(1'b0));
  ecp_periph u_per (.clk, .strobe_n, .autofd_n, .init_n, .selectin_n, .pd_out,
    .busy, .ack_n, .perror, .pp);

  // ------------------------------------------------------------------
  // host register cycles and comparisons
  // ------------------------------------------------------------------
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic chk_pin(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [10:0] a, input logic [7:0] e);
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1 io_rd = 1'b0;
    chk_pin({1'b0, io_rdata}, {1'b0, e});
    @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    {reset_n, io_rd, io_wr, dma_ack, io_addr, io_wdata} = '0;
    {select, fault_n} = 2'b11;
    void'($urandom(32'h25b5db55));
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 sf = 2'($urandom_range(3));
    {select, fault_n} = sf;
    chk_reg(ecp_pkg::OFF_DCR, 8'h00);
    chk_reg(ecp_pkg::OFF_ECR, 8'h15);
    chk_reg(ecp_pkg::OFF_DSR, {3'b110, sf, 3'b000});
    chk_pin({5'h0, selectin_n, init_n, strobe_n, autofd_n}, 9'h00b);
    wr(ecp_pkg::OFF_DCR, 8'hff);
    chk_reg(ecp_pkg::OFF_DCR, 8'h3f);
    chk_pin({5'h0, selectin_n, init_n, strobe_n, autofd_n}, 9'h004);
    wr(ecp_pkg::OFF_DCR, 8'h00);
    repeat (4) @(posedge clk);
    #1 u_per.fq.delete();
    $display("test registers done");
    wr(ecp_pkg::OFF_ECR, 8'h04);
    fault_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_pin({8'h0, irq}, 9'h001);
    fault_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk_pin({8'h0, irq}, 9'h000);
    $display("test fault done");
    for (int m = 0; m < 8; m++)
    begin
      wr(ecp_pkg::OFF_ECR, {3'(m), 5'h14});
      chk_reg(ecp_pkg::OFF_ECR, {3'(m), 5'h15});
      if (m == 7)
      begin
        chk_reg(ecp_pkg::OFF_FIFO, 8'h10);
        chk_reg(ecp_pkg::OFF_CFGB, 8'h00);
      end
    end
    $display("test modes done");
    wr(ecp_pkg::OFF_ECR, 8'hd4);
    for (int i = 0; i < 17; i++)
    begin
      d = 8'($urandom);
      wr(ecp_pkg::OFF_FIFO, d);
      if (i < 16)
        tq.push_back(d);
    end
    chk_reg(ecp_pkg::OFF_ECR, 8'hd6);
    for (int i = 0; i < 16; i++)
    begin
      d = tq.pop_front();
      chk_reg(ecp_pkg::OFF_FIFO, d);
    end
    chk_reg(ecp_pkg::OFF_FIFO, d);
    chk_reg(ecp_pkg::OFF_ECR, 8'hd5);
    $display("test fifo done");
    // compat fifo byte: strobe timed by the design, autofd follows dcr (high)
    wr(ecp_pkg::OFF_ECR, 8'h54);
    d = 8'($urandom);
    wr(ecp_pkg::OFF_FIFO, d);
    eq.push_back({1'b0, d});
    repeat (80) @(posedge clk);
    #1;
    wr(ecp_pkg::OFF_ECR, 8'h74);
    repeat (2) @(posedge clk);
    #1 chk_pin({7'h0, selectin_n, init_n}, 9'h003);
    d = 8'($urandom);
    wr(ecp_pkg::OFF_DATA, d);
    eq.push_back({1'b1, d});
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($urandom);
      wr(ecp_pkg::OFF_FIFO, d);
      eq.push_back({1'b0, d});
    end
    for (int i = 0; i < 800 && u_per.fq.size() < 5; i++) @(posedge clk);
    #1;
    for (int i = 0; i < 5; i++)
      chk_pin(u_per.fq.pop_front(), eq.pop_front());
    wr(ecp_pkg::OFF_ECR, 8'h7c);
    chk_pin({8'h0, dma_req}, 9'h001);
    $display("test forward done");
    d = 8'($urandom);
    u_per.rq.push_back(9'h003);
    u_per.rq.push_back({1'b1, d});
    repeat (4) tq.push_back(d);
    d = 8'($urandom);
    u_per.rq.push_back({1'b1, d});
    tq.push_back(d);
    wr(ecp_pkg::OFF_DCR, 8'h20);
    chk_pin({8'h0, init_n}, 9'h000);
    for (int i = 0; i < 800 && (u_per.rq.size() > 0 || !ack_n); i++) @(posedge clk);
    repeat (20) @(posedge clk);
    #1;
    for (int i = 0; i < 5; i++)
    begin
      d = tq.pop_front();
      chk_reg(ecp_pkg::OFF_FIFO, d);
    end
    chk_reg(ecp_pkg::OFF_ECR, 8'h7d);
    chk_pin({8'h0, dma_req}, 9'h000);
    $display("test reverse done");
    close_out();
  end
endmodule // ecp_parallel_port_tb

`default_nettype wire
